// ### hw/dspdec_pkg.sv
// Package for the instruction decode and issue block.
// Assumes 24-bit program words and a 32-bit APB register port.
package dspdec_pkg;
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_LSB = 16;
    localparam int REG_W = 4;
    localparam int TLIT_W = 10;
    localparam int PADDR_W = 23;
    localparam int FILE_W = 13;
    // APB map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ISSUED = 8'h08;
    localparam logic [7:0] REG_LAST = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    // Opcodes; zero opcode is the no-operation
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_CALLI = 8'h01;
    localparam logic [7:0] OP_CALL = 8'h02;
    localparam logic [7:0] OP_MOVL = 8'h03;
    localparam logic [7:0] OP_GOTO = 8'h04;
    localparam logic [7:0] OP_BRANCH = 8'h05;
    localparam logic [7:0] OP_GOTOI = 8'h06;
    localparam logic [7:0] OP_RET = 8'h07;
    localparam logic [7:0] OP_RETI = 8'h08;
    localparam logic [7:0] OP_SKIP = 8'h09;
    localparam logic [7:0] OP_TBLRD = 8'h0A;
    localparam logic [7:0] OP_TBLWR = 8'h0B;
    localparam logic [7:0] OP_MOVD = 8'h0C;
    localparam logic [3:0] CAT_FILE0 = 4'h3, CAT_FILE1 = 4'h4;
    localparam logic [3:0] CAT_BIT0 = 4'h5, CAT_BIT1 = 4'h6;
    localparam logic [3:0] CAT_LIT0 = 4'h7, CAT_LIT1 = 4'h8;
    localparam logic [3:0] CAT_MAC = 4'h9, CAT_ACC = 4'hA, CAT_CTRL = 4'h0;
    localparam int SZ_LSB = 0;
    localparam int LIT_SEP_BIT = 2;
    // Operand field positions inside the low 16 bits
    localparam int F_HI = 12, F_DMODE = 10, F_DEST = 6, F_SMODE = 4, F_SRC = 0;
    localparam int F_DFLT = 13, F_IND = 15, F_ONFILE = 14, F_BFILE = 4, F_BBASE = 10;
    localparam int F_BSRC = 4, F_BMODE = 8, F_TLIT = 4, F_LIT5 = 4, F_LDMODE = 9;
    localparam int F_ACC = 15, F_MUL = 12, F_XPF = 8, F_YPF = 4, F_WBACK = 0;
    localparam int F_SHREG = 14, F_SHLIT = 8, F_SHSRC = 8, F_PA_LO = 1, F_PA_HI_W = 7;
    localparam logic [9:0] LIT_BYTE_MAX = 10'h0FF;
    localparam logic [3:0] WBACK_REG = 4'hD;
    localparam logic [1:0] WBACK_NONE = 2'h0, WBACK_DIRECT = 2'h1, WBACK_POSTINC2 = 2'h2;
    localparam logic [1:0] XTRA_NONE = 2'h0, XTRA_ONE = 2'h1, XTRA_TWO = 2'h2;

    typedef enum logic [2:0] {
        DSPDEC_NOP, DSPDEC_WW, DSPDEC_FILE, DSPDEC_BIT,
        DSPDEC_LIT, DSPDEC_MAC, DSPDEC_ACC, DSPDEC_CTRL
    } dspdec_cls_t;
    typedef enum logic [1:0] {SZ_WORD, SZ_BYTE, SZ_DOUBLE, SZ_SHADOW} dspdec_size_t;
    typedef logic [3:0] dspdec_reg_t;

    typedef struct packed {
        logic carry_flag;
        logic digit_carry_flag;
        logic negative_flag;
        logic overflow_flag;
        logic zero_flag;
        logic acc_a_overflow_flag;
        logic acc_b_overflow_flag;
        logic acc_a_saturate_flag;
        logic acc_b_saturate_flag;
    } dspdec_flags_t;

    typedef struct packed {
        logic [7:0] opcode;
        dspdec_cls_t cls;
        dspdec_size_t size;
        logic shadow;
        dspdec_reg_t base_operand_reg;
        dspdec_reg_t source_operand_reg;
        logic [1:0] src_mode;
        dspdec_reg_t dest_operand_reg;
        logic [1:0] dest_mode;
        logic [12:0] file_addr;
        logic dest_is_default_working_reg;
        logic [3:0] bit_select_field;
        logic bit_from_base;
        logic bit_on_file;
        logic [9:0] ten_bit_literal;
        logic acc_b;
        logic [2:0] mul_pair;
        logic [3:0] x_prefetch;
        logic [3:0] y_prefetch;
        logic wback_en;
        logic wback_indirect;
        dspdec_reg_t acc_writeback_dest;
        logic shift_by_reg;
        logic [5:0] shift_lit;
        logic [22:0] program_address_literal;
        logic nop;
    } dspdec_dec_t;
endpackage : dspdec_pkg

// ### hw/dspdec_core.sv
// Instruction decode and issue stage with an APB status/control port.
// Assumes program words arrive in order with valid/ready and that the
// execute stage reports condition, redirect and skip along with the word.
//
// Behaviour
// RULE_01 - Single words are 24 bits; top eight bits are the opcode.
// RULE_02 - Double-word instructions join two consecutive words into one decode.
// RULE_03 - A lone second word has zero opcode and runs as no-operation.
// RULE_04 - Plain single-word instructions take one issue slot.
// RULE_05 - True condition or redirect adds one no-operation slot.
// RULE_06 - Branch, indirect call/goto, table access take two; returns three.
// RULE_07 - Taken skip costs two slots, three when skipping a double word.
// RULE_08 - Double-word moves and double-word instructions take exactly two slots.
// RULE_09 - Register ops decode base, moded source and moded destination.
// RULE_10 - File ops decode file address and file-or-W0 destination.
// RULE_11 - Bit ops take bit from literal or base register; target W or file.
// RULE_12 - Literal arithmetic writes back to first source unless destination given.
// RULE_13 - Ten-bit literal limited to 255 in byte mode, 1023 in word.
// RULE_14 - Program address literal always has a zero least significant bit.
// RULE_15 - Four-bit bit select indexes bits 0 to 15.
// RULE_16 - Multiply ops name accumulator, multiplier pair, prefetches, write-back.
// RULE_17 - Accumulator write-back only to W13 direct or post-increment by two.
// RULE_18 - Other accumulator ops name accumulator, operand and shift source.
// RULE_19 - Keep five general and four accumulator status bits.
// RULE_20 - Size suffix selects byte, word or double; word default; shadow separate.
// RULE_21 - Extra cycles become no-operation bubbles, program order kept.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module dspdec_core
    import dspdec_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WORD_W-1:0] fetch_word,
    input wire logic fetch_valid,
    output logic fetch_ready,
    input wire logic ex_cond_true,
    input wire logic ex_pc_redirect,
    input wire logic ex_skip_taken,
    input wire logic flag_we,
    input wire dspdec_flags_t flag_in,
    output logic issue_valid,
    output logic issue_bubble,
    output dspdec_dec_t issue_dec,
    output dspdec_flags_t status_flags
);
    typedef enum logic [1:0] {ST_RUN, ST_SECOND, ST_SKIP2} dspdec_state_t;

    dspdec_state_t state_r, state_nxt;
    logic en_r;
    logic skip_pend_r, skip_pend_nxt;
    logic [1:0] bub_r, bub_nxt;
    logic [WORD_W-1:0] w1_r;
    logic [CNT_W-1:0] issued_r;
    logic [WORD_W-1:0] last_r;
    logic issue_valid_r, issue_valid_nxt, issue_bubble_r, issue_bubble_nxt;
    dspdec_dec_t dec_r, dec_nxt;
    dspdec_flags_t flags_r;

    function automatic dspdec_cls_t op_class(input logic [7:0] op);
        logic [3:0] cat;
        cat = op[7:4];
        if (op == OP_NOP) op_class = DSPDEC_NOP;
        else if (cat == CAT_CTRL) op_class = DSPDEC_CTRL;
        else if (cat == CAT_FILE0 || cat == CAT_FILE1) op_class = DSPDEC_FILE;
        else if (cat == CAT_BIT0 || cat == CAT_BIT1) op_class = DSPDEC_BIT;
        else if (cat == CAT_LIT0 || cat == CAT_LIT1) op_class = DSPDEC_LIT;
        else if (cat == CAT_MAC) op_class = DSPDEC_MAC;
        else if (cat == CAT_ACC) op_class = DSPDEC_ACC;
        else op_class = DSPDEC_WW;
    endfunction : op_class

    function automatic dspdec_dec_t decode(input logic [WORD_W-1:0] w,
                                           input logic [WORD_W-1:0] w2);
        dspdec_dec_t d;
        logic [TLIT_W-1:0] lit;
        d = '0;
        d.opcode = w[OPC_LSB +: OPC_W]; // RULE_01
        d.cls = op_class(d.opcode);
        d.size = dspdec_size_t'(d.opcode[SZ_LSB +: 2]); // RULE_20
        d.shadow = (d.size == SZ_SHADOW); // RULE_20
        if (d.shadow) d.size = SZ_WORD;
        if (d.cls == DSPDEC_CTRL || d.cls == DSPDEC_MAC || d.cls == DSPDEC_ACC) begin
            d.size = SZ_WORD;
            d.shadow = 1'b0;
        end
        unique case (d.cls)
            DSPDEC_NOP: d.nop = 1'b1; // RULE_03
            DSPDEC_WW: begin // RULE_09
                d.base_operand_reg = w[F_HI +: REG_W];
                d.dest_mode = w[F_DMODE +: 2];
                d.dest_operand_reg = w[F_DEST +: REG_W];
                d.src_mode = w[F_SMODE +: 2];
                d.source_operand_reg = w[F_SRC +: REG_W];
            end
            DSPDEC_FILE: begin // RULE_10
                d.file_addr = w[0 +: FILE_W];
                d.dest_is_default_working_reg = w[F_DFLT];
            end
            DSPDEC_BIT: begin // RULE_11
                d.bit_from_base = w[F_IND];
                d.bit_on_file = w[F_ONFILE];
                d.bit_select_field = w[0 +: REG_W]; // RULE_15
                d.base_operand_reg = w[F_BBASE +: REG_W];
                if (w[F_ONFILE]) d.file_addr = {3'h0, w[F_BFILE +: TLIT_W]};
                else begin
                    d.source_operand_reg = w[F_BSRC +: REG_W];
                    d.src_mode = w[F_BMODE +: 2];
                end
            end
            DSPDEC_LIT: begin
                if (d.opcode[LIT_SEP_BIT]) begin // RULE_12
                    d.base_operand_reg = w[F_HI +: REG_W];
                    d.ten_bit_literal = {5'h00, w[F_LIT5 +: 5]};
                    d.dest_mode = w[F_LDMODE +: 2];
                    d.dest_operand_reg = w[F_SRC +: REG_W];
                end else begin
                    lit = w[F_TLIT +: TLIT_W];
                    // Byte mode masks the literal to its low eight bits rather than faulting
                    if (d.size == SZ_BYTE) lit = lit & LIT_BYTE_MAX; // RULE_13
                    d.ten_bit_literal = lit;
                    d.base_operand_reg = w[F_SRC +: REG_W]; // RULE_12
                    d.dest_operand_reg = w[F_SRC +: REG_W]; // RULE_12
                end
            end
            DSPDEC_MAC: begin // RULE_16
                d.acc_b = w[F_ACC];
                d.mul_pair = w[F_MUL +: 3];
                d.x_prefetch = w[F_XPF +: 4];
                d.y_prefetch = w[F_YPF +: 4];
                // Reserved write-back code behaves as none
                d.wback_en = (w[F_WBACK +: 2] == WBACK_DIRECT)
                    || (w[F_WBACK +: 2] == WBACK_POSTINC2);
                d.wback_indirect = (w[F_WBACK +: 2] == WBACK_POSTINC2); // RULE_17
                d.acc_writeback_dest = d.wback_en ? WBACK_REG : '0; // RULE_17
            end
            DSPDEC_ACC: begin // RULE_18
                d.acc_b = w[F_ACC];
                d.shift_by_reg = w[F_SHREG];
                if (w[F_SHREG]) d.base_operand_reg = w[F_SHSRC +: REG_W];
                else d.shift_lit = w[F_SHLIT +: 6];
                d.src_mode = w[F_SMODE +: 2];
                d.source_operand_reg = w[F_SRC +: REG_W];
            end
            DSPDEC_CTRL: // RULE_02 RULE_14
                d.program_address_literal = {w2[0 +: F_PA_HI_W], w[F_PA_LO +: 15], 1'b0};
        endcase
        decode = d;
    endfunction : decode

    wire logic [7:0] in_op = fetch_word[OPC_LSB +: OPC_W];
    wire logic in_dword = (in_op == OP_GOTO) || (in_op == OP_CALL) || (in_op == OP_MOVL);
    wire logic in_ret = (in_op == OP_RET) || (in_op == OP_RETI);
    wire logic in_fixed2 = (in_op == OP_BRANCH) || (in_op == OP_CALLI) || (in_op == OP_GOTOI)
        || (in_op == OP_TBLRD) || (in_op == OP_TBLWR) || (in_op == OP_MOVD);
    wire logic in_skip = (in_op == OP_SKIP) && ex_skip_taken;
    wire logic acc = fetch_valid && fetch_ready;
    wire logic [1:0] in_extra = in_ret ? XTRA_TWO : // RULE_06
        in_fixed2 ? XTRA_ONE : // RULE_06 RULE_08
        (ex_cond_true || ex_pc_redirect) ? XTRA_ONE : XTRA_NONE; // RULE_04 RULE_05

    // Stall fetch while bubbles drain so program order is kept
    assign fetch_ready = en_r && (bub_r == XTRA_NONE); // RULE_21

    always_comb begin
        state_nxt = state_r;
        skip_pend_nxt = skip_pend_r;
        bub_nxt = bub_r;
        issue_valid_nxt = 1'b0;
        issue_bubble_nxt = 1'b0;
        dec_nxt = dec_r;
        if (bub_r != XTRA_NONE) begin
            bub_nxt = bub_r - 2'd1;
            issue_valid_nxt = 1'b1;
            issue_bubble_nxt = 1'b1; // RULE_21
        end else if (acc) begin
            unique case (state_r)
                ST_RUN: begin
                    if (skip_pend_r) begin // RULE_07
                        skip_pend_nxt = 1'b0;
                        issue_valid_nxt = 1'b1;
                        issue_bubble_nxt = 1'b1;
                        if (in_dword) state_nxt = ST_SKIP2;
                    end else if (in_dword) begin
                        state_nxt = ST_SECOND; // RULE_02
                    end else begin
                        issue_valid_nxt = 1'b1;
                        dec_nxt = decode(fetch_word, '0);
                        bub_nxt = in_extra;
                        skip_pend_nxt = in_skip; // RULE_07
                    end
                end
                ST_SECOND: begin
                    issue_valid_nxt = 1'b1;
                    dec_nxt = decode(w1_r, fetch_word); // RULE_02
                    bub_nxt = XTRA_ONE; // RULE_08
                    state_nxt = ST_RUN;
                end
                ST_SKIP2: begin
                    issue_valid_nxt = 1'b1;
                    issue_bubble_nxt = 1'b1; // RULE_07
                    state_nxt = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RUN;
            skip_pend_r <= 1'b0;
            bub_r <= XTRA_NONE;
            issue_valid_r <= 1'b0;
            issue_bubble_r <= 1'b0;
            dec_r <= '0;
            w1_r <= '0;
        end else begin
            state_r <= state_nxt;
            skip_pend_r <= skip_pend_nxt;
            bub_r <= bub_nxt;
            issue_valid_r <= issue_valid_nxt;
            issue_bubble_r <= issue_bubble_nxt;
            dec_r <= dec_nxt;
            if (acc && state_r == ST_RUN) w1_r <= fetch_word;
        end
    end

    assign issue_valid = issue_valid_r;
    assign issue_bubble = issue_bubble_r;
    assign issue_dec = dec_r;
    assign status_flags = flags_r;

    // APB slave, zero wait states
    wire logic apb_wr = psel && penable && pwrite;
    wire logic hit_ctrl = (paddr == REG_CTRL);
    wire logic hit_status = (paddr == REG_STATUS);
    wire logic hit_issued = (paddr == REG_ISSUED);
    wire logic hit_last = (paddr == REG_LAST);
    wire logic hit_any = hit_ctrl || hit_status || hit_issued || hit_last;
    wire logic real_issue = issue_valid_nxt && !issue_bubble_nxt;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata = hit_ctrl ? {31'h0, en_r} :
        hit_status ? {23'h0, flags_r} :
        hit_issued ? 32'(issued_r) :
        hit_last ? {8'h00, last_r} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            flags_r <= '0;
            issued_r <= '0;
            last_r <= '0;
        end else begin
            if (apb_wr && hit_ctrl) en_r <= pwdata[CTRL_EN_BIT];
            if (flag_we) flags_r <= flag_in; // RULE_19
            if (real_issue) issued_r <= issued_r + 1'b1;
            if (acc) last_r <= fetch_word;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic plain_acc = acc && state_r == ST_RUN && !skip_pend_r && !in_dword
        && bub_r == XTRA_NONE;

    chk_plain_one: assert property (plain_acc && in_extra == XTRA_NONE // RULE_04
        |=> issue_valid && !issue_bubble && fetch_ready == en_r)
        else $error("plain instruction did not issue in one slot");
    chk_cond_two: assert property (plain_acc && !in_ret && !in_fixed2 // RULE_05
        && (ex_cond_true || ex_pc_redirect) |=> !issue_bubble ##1 issue_valid && issue_bubble)
        else $error("true condition did not add one bubble");
    chk_ret_three: assert property (plain_acc && in_ret // RULE_06
        |=> !issue_bubble ##1 (issue_valid && issue_bubble) [*2])
        else $error("return did not take three slots");
    chk_dword_two: assert property (acc && state_r == ST_SECOND // RULE_08
        |=> (issue_valid && !issue_bubble) ##1 (issue_valid && issue_bubble) ##1 !issue_bubble)
        else $error("double-word instruction did not take two slots");
    chk_skip_bubble: assert property (plain_acc && in_skip // RULE_07
        |=> ##[0:40] (acc && skip_pend_r) ##1 (issue_valid && issue_bubble))
        else $error("taken skip did not bubble the next word");
    chk_zero_nop: assert property (issue_valid && !issue_bubble // RULE_03
        && issue_dec.opcode == OP_NOP |-> issue_dec.nop)
        else $error("zero opcode word not treated as no-operation");
    chk_lit_byte: assert property (issue_valid && issue_dec.cls == DSPDEC_LIT // RULE_13
        && issue_dec.size == SZ_BYTE |-> issue_dec.ten_bit_literal <= LIT_BYTE_MAX)
        else $error("byte literal exceeds 255");
    chk_prog_lsb: assert property (issue_valid // RULE_14
        |-> !issue_dec.program_address_literal[0])
        else $error("program address literal is odd");
    chk_wback_w13: assert property (issue_valid && issue_dec.wback_en // RULE_17
        |-> issue_dec.acc_writeback_dest == WBACK_REG)
        else $error("write-back not W13");
    chk_flags_load: assert property (flag_we // RULE_19
        |=> status_flags == $past(flag_in))
        else $error("status flags not loaded");
    chk_order_stall: assert property (bub_r != XTRA_NONE // RULE_21
        |-> !fetch_ready)
        else $error("fetch accepted during bubble");

    chk_fixed_two: assert property (plain_acc && in_fixed2 // RULE_06
        |=> !issue_bubble ##1 (issue_valid && issue_bubble)
        ##1 !issue_bubble)
        else $error("fixed two-slot op misissued");
    chk_dword_first: assert property (acc && state_r == ST_RUN && !skip_pend_r && in_dword // RULE_02
        |=> !issue_valid)
        else $error("first word issued alone");
    chk_skip2_bub: assert property (acc && state_r == ST_SKIP2 // RULE_07
        |=> issue_valid && issue_bubble)
        else $error("skipped second word not a bubble");
    chk_skip_clear: assert property (acc && skip_pend_r |=> !skip_pend_r) // RULE_07
        else $error("skip removed more than one word");
    chk_ret_stall: assert property (plain_acc && in_ret // RULE_21
        |=> !fetch_ready [*2] ##1 fetch_ready == en_r)
        else $error("fetch not held during return bubbles");
    chk_bub_hold: assert property (issue_valid && issue_bubble // RULE_21
        |-> $stable(issue_dec))
        else $error("bubble changed the decode");
    chk_lit_dest: assert property (issue_valid && !issue_bubble // RULE_12
        && issue_dec.cls == DSPDEC_LIT && !issue_dec.opcode[LIT_SEP_BIT]
        |-> issue_dec.dest_operand_reg == issue_dec.base_operand_reg)
        else $error("literal result not written to source");
    chk_nop_issue: assert property (plain_acc && in_op == OP_NOP // RULE_03
        |=> issue_dec.nop)
        else $error("zero opcode not decoded as no-operation");

    cov_skip_taken: cover property (plain_acc && in_skip);
    cov_dword: cover property (acc && state_r == ST_SECOND);
    cov_skip_dword: cover property (acc && state_r == ST_SKIP2);
    cov_return: cover property (plain_acc && in_ret);
    cov_cond: cover property (plain_acc && ex_cond_true);
endmodule : dspdec_core

// ### tb/dspdec_prog_mem.sv
// Program memory model: offers stored words in order over valid/ready.
// Assumes the bench fills mem, then pulses start with the word count.
`timescale 1ns/1ps
module dspdec_prog_mem
    import dspdec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic slow,
    input wire logic [4:0] len,
    input wire logic fetch_ready,
    output logic [WORD_W-1:0] fetch_word,
    output logic fetch_valid,
    output logic [2:0] qual,
    output logic done
);
    // Entry: {skip, redirect, cond, word}
    logic [26:0] mem [0:15];
    logic [4:0] ptr_r;
    logic [4:0] len_r;
    logic gap_r;
    logic [26:0] last_r;
    wire logic have = ptr_r < len_r;
    wire logic take = fetch_valid && fetch_ready;
    assign fetch_valid = have && !gap_r;
    // Idle lines show the inverse of the last entry, never a stale copy
    assign fetch_word = fetch_valid ? mem[ptr_r[3:0]][23:0] : ~last_r[23:0];
    assign qual = fetch_valid ? mem[ptr_r[3:0]][26:24] : ~last_r[26:24];
    assign done = !have;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r <= 5'h00;
            len_r <= 5'h00;
            gap_r <= 1'b0;
            last_r <= 27'h0000000;
        end else if (start) begin
            ptr_r <= 5'h00;
            len_r <= len;
            gap_r <= 1'b0;
        end else begin
            // Words leave strictly in address order, held until taken
            if (take) begin
                ptr_r <= ptr_r + 5'h01;
                last_r <= mem[ptr_r[3:0]];
            end
            // Slow mode idles one cycle between words
            gap_r <= slow && take;
        end
    end
endmodule : dspdec_prog_mem

// ### tb/tb.sv
// Testbench for the decode and issue stage.
// Assumes the program memory model and APB with zero-wait answers.
`timescale 1ns/1ps
module tb
    import dspdec_pkg::*;
;
    localparam logic [26:0] QC = 27'h1000000;
    localparam logic [26:0] QR = 27'h2000000;
    localparam logic [26:0] QS = 27'h4000000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [WORD_W-1:0] fetch_word;
    logic fetch_valid;
    logic fetch_ready;
    logic [2:0] qual;
    logic flag_we = 1'b0;
    dspdec_flags_t flag_in = '0;
    logic issue_valid;
    logic issue_bubble;
    dspdec_dec_t issue_dec;
    dspdec_dec_t last_dec;
    dspdec_flags_t status_flags;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [4:0] len = 5'h00;
    logic done;
    int num_errors = 0;
    int n_checks = 0;
    int slots = 0;
    int bubs = 0;
    int exp_reals = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;
    always #50 pclk = ~pclk;
    dspdec_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready), .ex_cond_true(qual[0]), .ex_pc_redirect(qual[1]),
        .ex_skip_taken(qual[2]), .flag_we(flag_we), .flag_in(flag_in),
        .issue_valid(issue_valid), .issue_bubble(issue_bubble), .issue_dec(issue_dec),
        .status_flags(status_flags));
    dspdec_prog_mem u_mem (.pclk(pclk), .presetn(presetn), .start(start), .slow(slow),
        .len(len), .fetch_ready(fetch_ready), .fetch_word(fetch_word),
        .fetch_valid(fetch_valid), .qual(qual), .done(done));
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
        if (issue_valid === 1'b1) begin
            slots++;
            if (issue_bubble === 1'b1) bubs++;
            else last_dec <= issue_dec;
        end
    end
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val
    // Setup cycle, then access phase held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Loads up to three entries, runs them, checks slot and bubble counts
    task automatic run(input logic [26:0] a, b, c, input int n, es, eb, input logic sl);
        int s0;
        int b0;
        u_mem.mem[0] = a;
        u_mem.mem[1] = b;
        u_mem.mem[2] = c;
        s0 = slots;
        b0 = bubs;
        exp_reals += es - eb;
        len <= 5'(n);
        slow <= sl;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        @(posedge pclk);
        while (!(done === 1'b1 && fetch_ready === 1'b1)) @(posedge pclk);
        repeat (3) @(posedge pclk);
        cmp_val(32'(slots - s0), 32'(es));
        cmp_val(32'(bubs - b0), 32'(eb));
    endtask : run
    initial begin
        static logic [7:0] ops2 [6] = '{OP_BRANCH, OP_CALLI, OP_GOTOI,
            OP_TBLRD, OP_TBLWR, OP_MOVD};
        logic [26:0] w;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0);
        cmp_val(rd, 32'h0);
        apb(1'b0, REG_ISSUED, 32'h0);
        cmp_val(rd, 32'h0);
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        cmp_val(rd, 32'h1);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        cmp_val({31'h0, er}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        cmp_val(rd, 32'h0);
        // Flags are read-only over the bus; only flag_we loads them
        apb(1'b1, REG_STATUS, 32'h1FF);
        apb(1'b0, REG_STATUS, 32'h0);
        cmp_val(rd, 32'h0);
        flag_we <= 1'b1;
        flag_in <= dspdec_flags_t'(9'h155);
        @(posedge pclk);
        flag_we <= 1'b0;
        @(posedge pclk);
        cmp_val(32'(status_flags), 32'h155);
        apb(1'b0, REG_STATUS, 32'h0);
        cmp_val(32'(rd[8:0]), 32'h155);
        run(27'h0, 27'h0, 27'h0, 1, 1, 0, 1'b0);
        cmp_val(32'(last_dec.nop), 32'h1);
        w = {3'h0, 8'h20, 16'hABCD};
        run(w, w, w, 1, 1, 0, 1'b0);
        cmp_val(32'(last_dec.opcode), 32'h20);
        cmp_val(32'(last_dec.base_operand_reg), 32'(w[F_HI +: REG_W]));
        cmp_val(32'(last_dec.source_operand_reg), 32'(w[F_SRC +: REG_W]));
        cmp_val(32'(last_dec.dest_operand_reg), 32'(w[F_DEST +: REG_W]));
        run(w | QC, w, w, 1, 2, 1, 1'b0);
        run(w | QR, w, w, 1, 2, 1, 1'b0);
        foreach (ops2[i]) run({3'h0, ops2[i], 16'h0}, w, w, 1, 2, 1, 1'b0);
        run({3'h0, OP_RET, 16'h0}, w, w, 1, 3, 2, 1'b0);
        run({3'h0, OP_RETI, 16'h0}, w, w, 1, 3, 2, 1'b0);
        // Double word, slow memory stalls between the two halves
        run({3'h0, OP_GOTO, 16'h2345}, 27'h0000055, w, 2, 2, 1, 1'b1);
        cmp_val(32'(last_dec.opcode), 32'(OP_GOTO));
        cmp_val(32'(last_dec.program_address_literal), 32'h552344);
        run({3'h0, OP_SKIP, 16'h0} | QS, w, w, 2, 2, 1, 1'b0);
        run({3'h0, OP_SKIP, 16'h0} | QS, {3'h0, OP_GOTO, 16'h0}, 27'h1, 3, 3, 2, 1'b0);
        run({3'h0, OP_SKIP, 16'h0}, w, w, 2, 2, 0, 1'b0);
        run({3'h0, 8'h71, 16'h3FF0}, w, w, 1, 1, 0, 1'b0);
        cmp_val(32'(last_dec.ten_bit_literal), 32'h0FF);
        cmp_val(32'(last_dec.size), 32'(SZ_BYTE));
        run({3'h0, 8'h70, 16'h3FF0}, w, w, 1, 1, 0, 1'b0);
        cmp_val(32'(last_dec.ten_bit_literal), 32'h3FF);
        cmp_val(32'(last_dec.size), 32'(SZ_WORD));
        run({3'h0, 8'h30, 16'h3ABC}, w, w, 1, 1, 0, 1'b0);
        cmp_val(32'(last_dec.file_addr), 32'h1ABC);
        cmp_val(32'(last_dec.dest_is_default_working_reg), 32'h1);
        // Two plain words back to back: last real issue is the second
        run(w, {3'h0, 8'h21, 16'h0}, w, 2, 2, 0, 1'b0);
        cmp_val(32'(last_dec.opcode), 32'h21);
        apb(1'b0, REG_ISSUED, 32'h0);
        cmp_val(rd, 32'(exp_reals));
        give_verdict();
    end
endmodule : tb
